// ===== rfs_consts.svh
/*
  Constants of the regulator fault supervisor: register offsets, field
  positions, reset values and timing counts. Assumes a 125 MHz bus clock.
*/
`ifndef RFS_CONSTS_SVH
`define RFS_CONSTS_SVH
`define RFS_CLK_MHZ 125
`define RFS_PG_FILTER_NS 5000
`define RFS_PG_FILTER_CYC ((`RFS_PG_FILTER_NS * `RFS_CLK_MHZ) / 1000)
`define RFS_RELEASE_DELAY_US 1000
`define RFS_RELEASE_DELAY_CYC (`RFS_RELEASE_DELAY_US * `RFS_CLK_MHZ)
`define RFS_BLANK_NS 120
`define RFS_BLANK_CYC (((`RFS_BLANK_NS * `RFS_CLK_MHZ) + 999) / 1000)
`define RFS_DIODE_NS 50
`define RFS_DIODE_CYC (((`RFS_DIODE_NS * `RFS_CLK_MHZ) + 999) / 1000)
`define RFS_OC_COUNT_MAX 120
`define RFS_CAP_OPEN_MAX 7
`define RFS_CAP_SHORT_MAX 120
`define RFS_OFF_CTRL 12'h000
`define RFS_OFF_STATUS 12'h004
`define RFS_OFF_COUNTS 12'h008
`define RFS_CTRL_PFM_BIT 0
`define RFS_CTRL_ENABLE_BIT 1
`define RFS_CTRL_RESET 2'h2
`endif

// ===== rfs_pkg.sv
/*
  Types of the regulator fault supervisor. Assumes rfs_consts.svh for numbers.
*/
`default_nettype none
package rfs_pkg;
  typedef enum logic [1:0] {
    rfs_st_off = 2'b00,
    rfs_st_start = 2'b01,
    rfs_st_run = 2'b10,
    rfs_st_hiccup = 2'b11
  } rfs_state_type;
  typedef struct packed {
    logic input_low_lockout;
    logic thermal_trip;
    logic overvoltage_guard;
    logic window_high;
    logic window_low_pwm;
    logic window_low_pfm;
    logic overcurrent_guard;
    logic error_amp_clamped;
    logic ss_above_hiccup_en;
    logic ss_below_reset;
    logic ss_above_offset;
    logic cap_open;
    logic cap_short;
    logic phase_node_negative;
    logic extreme_current;
    logic osc_pulse;
  } rfs_flags_type;
  typedef struct packed {
    logic switch_stop;
    logic high_side_off;
    logic low_side_keep;
    logic comp_pull_down;
    logic ss_sink;
    logic ss_source;
    logic ss_discharge;
    logic half_current_limit;
  } rfs_drive_type;
endpackage : rfs_pkg
`default_nettype wire

// ===== rfs_supervisor.sv
/*
  Regulator fault supervisor: power-good reset, lockout, overcurrent and
  hiccup sequencing, gate-drive capacitor and catch-diode faults, and an
  AHB-Lite register slave. Assumes comparator flags arrive asynchronously
  and the pull-up outside turns the open-drain low drive into a level.
*/
// Behaviour
// RULE1: Reset output rises only after fixed delay
// RULE2: PWM good between 92.5% and 110%
// RULE3: PFM good above 87.5%, no limit
// RULE4: Filter window comparators about 5 us
// RULE5: Overvoltage, undervoltage, thermal drop reset immediately
// RULE6: Lockout holds regulator disabled
// RULE7: Overcurrent stops high side until clock
// RULE8: Blank current limit after turn-on
// RULE9: Overcurrent counter off below 2.3 V
// RULE10: Count only with enable and clamp
// RULE11: Clamp release clears overcurrent counter
// RULE12: Count 120 sets hiccup, pull-down, sink
// RULE13: 200 mV clears hiccup, starts sourcing
// RULE14: Resume switching above 400 mV offset
// RULE15: Capacitor missing: hiccup after 7 cycles
// RULE16: Capacitor short: 120 cycles without overvoltage
// RULE17: Capacitor faults non-latched, auto recovery
// RULE18: Negative phase node 50 ns: hiccup
// RULE19: Shorted diode: hiccup immediately
// RULE20: Feedback 880 mV stops switching, reset low
// RULE21: Keep low side during overvoltage
// RULE22: PFM fault moves to half-limit PWM
// RULE23: Thermal trip stops switching, holds low
// RULE24: Synchronise comparator flags through two flops
// RULE25: Lockout clears counters and hiccup latch
`include "rfs_consts.svh"
`default_nettype none
module rfs_supervisor #(
  parameter int unsigned RELEASE_CYC = `RFS_RELEASE_DELAY_CYC,
  parameter int unsigned FILTER_CYC = `RFS_PG_FILTER_CYC
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Comparator flags from the power stage
  input wire rfs_pkg::rfs_flags_type flags_async,
  // Controls to the power stage
  output rfs_pkg::rfs_drive_type drive,
  // Open-drain power-good reset
  output logic power_good_reset_n_o,
  output logic power_good_reset_n_oe
);
  rfs_pkg::rfs_flags_type sync1;
  rfs_pkg::rfs_flags_type flg;
  rfs_pkg::rfs_state_type state;
  logic [1:0] ctrl;
  logic pfm_mode;
  logic fault_in_pfm;
  logic pg_raw;
  logic pg_filt;
  logic [15:0] filt_cnt;
  logic [31:0] rel_cnt;
  logic pg_out;
  logic [7:0] oc_cnt;
  logic [7:0] cap_open_cnt;
  logic [7:0] cap_short_cnt;
  logic [3:0] blank_cnt;
  logic [3:0] diode_cnt;
  logic hs_cut;
  logic osc_d;
  logic ocg_d;
  logic hiccup_req;
  logic stop_now;
  logic wr_pend;
  logic [11:0] wr_addr;
  logic osc_edge;
  logic oc_edge;

  // Second flop is the only reader of the first
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1 <= '0;
      flg <= '0;
    end else begin
      sync1 <= flags_async; // [RULE24]
      flg <= sync1; // [RULE24]
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      osc_d <= 1'b0;
      ocg_d <= 1'b0;
    end else begin
      osc_d <= flg.osc_pulse;
      ocg_d <= flg.overcurrent_guard;
    end
  end
  assign osc_edge = flg.osc_pulse && !osc_d;
  assign oc_edge = flg.overcurrent_guard && !ocg_d;

  // Window comparator with mode-dependent limits
  assign pfm_mode = ctrl[`RFS_CTRL_PFM_BIT] && !fault_in_pfm; // [RULE22]
  always_comb begin
    if (pfm_mode) begin
      pg_raw = !flg.window_low_pfm; // [RULE3]
    end else begin
      pg_raw = !flg.window_low_pwm && !flg.window_high; // [RULE2]
    end
  end

  // Hysteresis sits in the analog comparators; ripple filtered here
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pg_filt <= 1'b0;
      filt_cnt <= '0;
    end else if (pg_raw == pg_filt) begin
      filt_cnt <= '0;
    end else if (filt_cnt >= 16'(FILTER_CYC - 1)) begin
      pg_filt <= pg_raw; // [RULE4]
      filt_cnt <= '0;
    end else begin
      filt_cnt <= filt_cnt + 16'h0001;
    end
  end

  assign stop_now = flg.overvoltage_guard || flg.thermal_trip || flg.input_low_lockout;

  // Fall is immediate, rise waits the release delay
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pg_out <= 1'b0;
      rel_cnt <= '0;
    end else if (stop_now || !pg_filt || !ctrl[`RFS_CTRL_ENABLE_BIT]) begin
      pg_out <= 1'b0; // [RULE5] [RULE20] [RULE23]
      rel_cnt <= '0;
    end else if (rel_cnt >= RELEASE_CYC - 1) begin
      pg_out <= 1'b1; // [RULE1]
    end else begin
      rel_cnt <= rel_cnt + 32'h0000_0001;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      power_good_reset_n_o <= 1'b0;
      power_good_reset_n_oe <= 1'b1;
    end else begin
      power_good_reset_n_o <= 1'b0;
      power_good_reset_n_oe <= !pg_out;
    end
  end

  // A capacitor, negative phase node or extreme current fault in PFM drops to half-limit PWM until the PFM bit is cleared or lockout
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fault_in_pfm <= 1'b0;
    end else if (!ctrl[`RFS_CTRL_PFM_BIT] || flg.input_low_lockout) begin
      fault_in_pfm <= 1'b0;
    end else if (flg.cap_open || flg.cap_short || flg.phase_node_negative ||
                 flg.extreme_current) begin
      fault_in_pfm <= 1'b1; // [RULE22]
    end
  end

  // Leading-edge blanking and pulse-by-pulse cut-off
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      blank_cnt <= '0;
      hs_cut <= 1'b0;
    end else if (osc_edge) begin
      blank_cnt <= 4'(`RFS_BLANK_CYC); // [RULE8]
      hs_cut <= 1'b0; // [RULE7]
    end else begin
      if (blank_cnt != 4'h0) begin
        blank_cnt <= blank_cnt - 4'h1;
      end
      if (blank_cnt == 4'h0 && flg.overcurrent_guard) begin
        hs_cut <= 1'b1; // [RULE7] [RULE8]
      end
    end
  end

  // Overcurrent counter
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      oc_cnt <= '0;
    end else if (flg.input_low_lockout || state == rfs_pkg::rfs_st_hiccup) begin
      oc_cnt <= '0; // [RULE25]
    end else if (!flg.error_amp_clamped) begin
      oc_cnt <= '0; // [RULE11]
    end else if (!flg.ss_above_hiccup_en) begin
      oc_cnt <= '0; // [RULE9]
    end else if (oc_edge && blank_cnt == 4'h0 && oc_cnt < 8'(`RFS_OC_COUNT_MAX)) begin
      // Spikes inside blanking never reach the counter
      oc_cnt <= oc_cnt + 8'h01; // [RULE10] [RULE8]
    end
  end

  // Capacitor faults count PWM cycles, cleared when fault goes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cap_open_cnt <= '0;
      cap_short_cnt <= '0;
    end else if (flg.input_low_lockout || state == rfs_pkg::rfs_st_hiccup) begin
      cap_open_cnt <= '0; // [RULE25]
      cap_short_cnt <= '0;
    end else begin
      if (!flg.cap_open) begin
        cap_open_cnt <= '0; // [RULE17]
      end else if (osc_edge && cap_open_cnt < 8'(`RFS_CAP_OPEN_MAX)) begin
        cap_open_cnt <= cap_open_cnt + 8'h01; // [RULE15]
      end
      if (!flg.cap_short || flg.overvoltage_guard) begin
        cap_short_cnt <= '0; // [RULE16] [RULE17]
      end else if (osc_edge && cap_short_cnt < 8'(`RFS_CAP_SHORT_MAX)) begin
        cap_short_cnt <= cap_short_cnt + 8'h01; // [RULE16]
      end
    end
  end

  // Negative phase node must persist past the glitch time
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      diode_cnt <= '0;
    end else if (!flg.phase_node_negative) begin
      diode_cnt <= '0;
    end else if (diode_cnt <= 4'(`RFS_DIODE_CYC)) begin
      diode_cnt <= diode_cnt + 4'h1; // [RULE18]
    end
  end

  assign hiccup_req = oc_cnt == 8'(`RFS_OC_COUNT_MAX) || // [RULE12]
    cap_open_cnt == 8'(`RFS_CAP_OPEN_MAX) || // [RULE15]
    cap_short_cnt == 8'(`RFS_CAP_SHORT_MAX) || // [RULE16]
    diode_cnt > 4'(`RFS_DIODE_CYC) || // [RULE18]
    flg.extreme_current; // [RULE19]

  // Soft-start and hiccup sequencing
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= rfs_pkg::rfs_st_off;
    end else if (flg.input_low_lockout || !ctrl[`RFS_CTRL_ENABLE_BIT]) begin
      state <= rfs_pkg::rfs_st_off; // [RULE6] [RULE25]
    end else begin
      unique case (state)
        rfs_pkg::rfs_st_off: begin
          if (flg.ss_below_reset && !flg.thermal_trip) begin
            state <= rfs_pkg::rfs_st_start;
          end
        end
        rfs_pkg::rfs_st_start: begin
          if (flg.thermal_trip) begin
            state <= rfs_pkg::rfs_st_off; // [RULE23]
          end else if (flg.ss_above_offset) begin
            state <= rfs_pkg::rfs_st_run; // [RULE14]
          end
        end
        rfs_pkg::rfs_st_run: begin
          if (flg.thermal_trip) begin
            state <= rfs_pkg::rfs_st_off; // [RULE23]
          end else if (hiccup_req) begin
            state <= rfs_pkg::rfs_st_hiccup; // [RULE12]
          end
        end
        rfs_pkg::rfs_st_hiccup: begin
          if (flg.ss_below_reset) begin
            state <= rfs_pkg::rfs_st_start; // [RULE13]
          end
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      drive <= '0;
      drive.switch_stop <= 1'b1;
      drive.ss_discharge <= 1'b1;
    end else begin
      drive.switch_stop <= state != rfs_pkg::rfs_st_run ||
        flg.overvoltage_guard; // [RULE6] [RULE14] [RULE20]
      drive.high_side_off <= hs_cut || state != rfs_pkg::rfs_st_run; // [RULE7]
      drive.low_side_keep <= flg.overvoltage_guard && !flg.thermal_trip; // [RULE21]
      drive.comp_pull_down <= state == rfs_pkg::rfs_st_hiccup ||
        state == rfs_pkg::rfs_st_off; // [RULE12] [RULE23]
      drive.ss_sink <= state == rfs_pkg::rfs_st_hiccup; // [RULE12]
      drive.ss_source <= state == rfs_pkg::rfs_st_start ||
        state == rfs_pkg::rfs_st_run; // [RULE13]
      drive.ss_discharge <= state == rfs_pkg::rfs_st_off; // [RULE23]
      drive.half_current_limit <= fault_in_pfm; // [RULE22]
    end
  end

  // AHB-Lite: zero wait states, write data taken in data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= '0;
    end else if (hready) begin
      wr_pend <= hsel && htrans[1] && hwrite;
      wr_addr <= haddr;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl <= `RFS_CTRL_RESET;
    end else if (wr_pend && wr_addr == `RFS_OFF_CTRL) begin
      ctrl <= hwdata[1:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= '0;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      unique case (haddr)
        `RFS_OFF_CTRL: hrdata <= {30'h0, ctrl};
        `RFS_OFF_STATUS: hrdata <= {24'h0, pg_out, pg_filt, fault_in_pfm, hs_cut,
                                    2'h0, state};
        `RFS_OFF_COUNTS: hrdata <= {8'h0, cap_short_cnt, cap_open_cnt, oc_cnt};
        default: hrdata <= '0;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // Checks
  a_release_delay: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(pg_out) |-> $past(pg_filt) && !$past(stop_now) &&
    $past(rel_cnt) >= RELEASE_CYC - 1) // [RULE1]
    else $error("reset output rose without good window");
  a_fast_drop: assert property (@(posedge hclk) disable iff (!hresetn)
    flg.overvoltage_guard |=> !pg_out) // [RULE5]
    else $error("reset output not dropped on overvoltage");
  a_lockout_idle: assert property (@(posedge hclk) disable iff (!hresetn)
    flg.input_low_lockout |=> ##1 drive.switch_stop && oc_cnt == 8'h00) // [RULE6]
    else $error("switching during lockout");
  a_clamp_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    !flg.error_amp_clamped |=> oc_cnt == 8'h00) // [RULE11]
    else $error("counter kept without clamp");
  a_count_gate: assert property (@(posedge hclk) disable iff (!hresetn)
    !flg.ss_above_hiccup_en |=> oc_cnt == 8'h00) // [RULE9]
    else $error("counter ran below enable level");
  a_hiccup_entry: assert property (@(posedge hclk) disable iff (!hresetn)
    state == rfs_pkg::rfs_st_run && flg.extreme_current && !flg.thermal_trip &&
    !flg.input_low_lockout && ctrl[1] |=> state == rfs_pkg::rfs_st_hiccup) // [RULE19]
    else $error("no hiccup on shorted diode");
  a_hiccup_sink: assert property (@(posedge hclk) disable iff (!hresetn)
    state == rfs_pkg::rfs_st_hiccup |=> drive.ss_sink && drive.comp_pull_down) // [RULE12]
    else $error("hiccup without sink");
  a_ovp_stop: assert property (@(posedge hclk) disable iff (!hresetn)
    flg.overvoltage_guard |=> drive.switch_stop) // [RULE20]
    else $error("switching during overvoltage");
  c_hiccup: cover property (@(posedge hclk) state == rfs_pkg::rfs_st_hiccup);
  c_good: cover property (@(posedge hclk) $rose(pg_out));
  c_half: cover property (@(posedge hclk) fault_in_pfm);
endmodule : rfs_supervisor
`default_nettype wire

// ===== rfs_stage_model.sv
/*
  Power stage model: comparator flags, oscillator pulses and pin pull-up.
  Assumes the bench commands analog levels through cmd.
*/
`default_nettype none
module rfs_stage_model (
  // Clock
  input wire logic clk,
  // Commanded levels and pin drive
  input wire rfs_pkg::rfs_flags_type cmd,
  input wire logic pin_o,
  input wire logic pin_oe,
  // Flags and resolved pin
  output rfs_pkg::rfs_flags_type flags,
  output logic pin
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [5:0] ph = 6'h00;
  rfs_pkg::rfs_flags_type f;
  // Period of 40 clocks
  always @(posedge clk) begin
    ph <= (ph == 6'h27) ? 6'h00 : ph + 6'h01;
  end
  // Spike inside blanking, real trip well after it
  always_comb begin
    f = cmd;
    f.osc_pulse = ph < 6'h02;
    f.overcurrent_guard = cmd.overcurrent_guard && (ph inside {[3:4], [25:27]});
  end
  // Skewed so flags stay asynchronous to the clock
  always @(f) begin
    flags <= #2 f;
  end
  // External pull-up
  assign pin = pin_oe ? pin_o : 1'b1;
endmodule : rfs_stage_model
`default_nettype wire

// ===== regulator_fault_supervisor_tb_top.sv
/*
  Self-checking bench of the fault supervisor.
  Assumes rfs_stage_model as the power stage and a zero-wait bus slave.
*/
`default_nettype none
module regulator_fault_supervisor_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [11:0] haddr = 12'h000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic pin_o;
  logic pin_oe;
  logic pin;
  rfs_pkg::rfs_flags_type cmd = '0;
  rfs_pkg::rfs_flags_type flags;
  rfs_pkg::rfs_drive_type drive;
  int n_mismatch = 0;
  int compares = 0;
  logic [31:0] seed = 32'h73f5;
  logic [31:0] q;
  initial forever #4 hclk = ~hclk;
  rfs_supervisor #(.RELEASE_CYC(20), .FILTER_CYC(4)) i_dut (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .flags_async(flags), .drive(drive), .power_good_reset_n_o(pin_o),
    .power_good_reset_n_oe(pin_oe));
  rfs_stage_model i_stage (.clk(hclk), .cmd(cmd), .pin_o(pin_o), .pin_oe(pin_oe),
    .flags(flags), .pin(pin));
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs
  task automatic summarize;
    $display("Mismatches %0d, compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : summarize
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge hclk);
    #1;
  endtask : tick
  task automatic rdy;
    int k;
    k = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1 && k < 50) begin
      k++;
      @(posedge hclk);
    end
    if (hreadyout !== 1'b1) begin
      chk("hreadyout", 1, hreadyout);
      summarize();
    end
  endtask : rdy
  // Single word transfer; read data lands in q
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rdy();
    q = hrdata;
    chk("hresp", 0, hresp);
  endtask : bus
  task automatic st(input logic [1:0] s, input int lim);
    for (int i = 0; i < lim; i++) begin
      bus(1'b0, 12'h004, 32'h0);
      if (q[1:0] === s) return;
    end
    chk("state", s, q[1:0]);
    summarize();
  endtask : st
  task automatic pw(input logic e, input int lim);
    for (int i = 0; i < lim && pin !== e; i++) tick(1);
    chk("pin", e, pin);
  endtask : pw
  task automatic nohic(input int n);
    tick(n);
    bus(1'b0, 12'h004, 32'h0);
    chk("not hiccup", 1, q[1:0] !== 2'h3);
  endtask : nohic
  task automatic at(input int p);
    for (int i = 0; i < 41 && i_stage.ph != p; i++) tick(1);
  endtask : at
  task automatic hic(input int lim);
    st(2'h3, lim);
    tick(3);
    chk("comp_pull_down", 1, drive.comp_pull_down);
    chk("ss_sink", 1, drive.ss_sink);
  endtask : hic
  task automatic recover;
    cmd.ss_below_reset <= 1'b1;
    cmd.ss_above_offset <= 1'b0;
    cmd.ss_above_hiccup_en <= 1'b0;
    st(2'h1, 40);
    tick(3);
    chk("ss_source", 1, drive.ss_source);
    chk("ss_sink", 0, drive.ss_sink);
    cmd.ss_below_reset <= 1'b0;
    cmd.ss_above_offset <= 1'b1;
    st(2'h2, 40);
    tick(3);
    chk("switch_stop", 0, drive.switch_stop);
  endtask : recover
  initial begin
    logic g;
    logic prev;
    logic lo;
    logic lop;
    logic pfm;
    cmd.window_low_pwm = 1'b1;
    cmd.window_low_pfm = 1'b1;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, 12'h008, 32'h0);
    chk("counts", 0, q);
    bus(1'b0, 12'h00c + {seed[9:2], 2'b00}, 32'h0);
    chk("unmapped", 0, q);
    recover();
    cmd.window_low_pwm <= 1'b0;
    cmd.window_low_pfm <= 1'b0;
    tick(18);
    chk("pin held", 0, pin);
    pw(1'b1, 30);
    prev = 1'b1;
    // Random window and mode; a drop passes the filter, a rise waits the delay
    for (int i = 0; i < 16; i++) begin
      seed = xs(seed);
      pfm = seed[4];
      lop = seed[1] & seed[2];
      lo = lop | seed[3];
      g = pfm ? !lop : !(seed[0] | lo);
      bus(1'b1, 12'h000, {30'h0, 1'b1, pfm});
      cmd.window_high <= seed[0];
      cmd.window_low_pwm <= lo;
      cmd.window_low_pfm <= lop;
      tick(10);
      chk("pin fast", g & prev, pin);
      tick(36);
      chk("pin window", g, pin);
      prev = g;
    end
    bus(1'b1, 12'h000, 32'h3);
    cmd.phase_node_negative <= 1'b1;
    tick(2);
    cmd.phase_node_negative <= 1'b0;
    tick(6);
    chk("half_current_limit", 1, drive.half_current_limit);
    bus(1'b1, 12'h000, 32'h2);
    tick(3);
    chk("half_current_limit", 0, drive.half_current_limit);
    cmd.window_high <= 1'b0;
    cmd.window_low_pwm <= 1'b0;
    cmd.window_low_pfm <= 1'b0;
    cmd.thermal_trip <= 1'b1;
    tick(6);
    chk("pin", 0, pin);
    chk("switch_stop", 1, drive.switch_stop);
    chk("ss_discharge", 1, drive.ss_discharge);
    cmd.thermal_trip <= 1'b0;
    recover();
    cmd.overvoltage_guard <= 1'b1;
    cmd.cap_short <= 1'b1;
    tick(6);
    chk("pin", 0, pin);
    chk("switch_stop", 1, drive.switch_stop);
    chk("low_side_keep", 1, drive.low_side_keep);
    nohic(40 * 130);
    cmd.overvoltage_guard <= 1'b0;
    nohic(40 * 100);
    hic(300);
    cmd.cap_short <= 1'b0;
    recover();
    pw(1'b1, 60);
    cmd.cap_open <= 1'b1;
    nohic(200);
    hic(60);
    cmd.cap_open <= 1'b0;
    recover();
    cmd.phase_node_negative <= 1'b1;
    tick(2);
    cmd.phase_node_negative <= 1'b0;
    nohic(30);
    cmd.phase_node_negative <= 1'b1;
    tick(12);
    cmd.phase_node_negative <= 1'b0;
    hic(20);
    recover();
    cmd.extreme_current <= 1'b1;
    tick(2);
    cmd.extreme_current <= 1'b0;
    hic(20);
    recover();
    cmd.ss_above_hiccup_en <= 1'b1;
    cmd.error_amp_clamped <= 1'b1;
    cmd.overcurrent_guard <= 1'b1;
    at(36);
    chk("high_side_off", 1, drive.high_side_off);
    at(12);
    chk("high_side_off", 0, drive.high_side_off);
    tick(40 * 20);
    bus(1'b0, 12'h008, 32'h0);
    chk("oc count", 1, q[7:0] > 8'd15 && q[7:0] < 8'd25);
    cmd.error_amp_clamped <= 1'b0;
    tick(10);
    bus(1'b0, 12'h008, 32'h0);
    chk("oc count", 0, q[7:0]);
    cmd.ss_above_hiccup_en <= 1'b0;
    cmd.error_amp_clamped <= 1'b1;
    tick(40 * 10);
    bus(1'b0, 12'h008, 32'h0);
    chk("oc count", 0, q[7:0]);
    cmd.ss_above_hiccup_en <= 1'b1;
    nohic(40 * 110);
    hic(300);
    cmd.overcurrent_guard <= 1'b0;
    recover();
    cmd.ss_above_hiccup_en <= 1'b1;
    cmd.overcurrent_guard <= 1'b1;
    tick(40 * 10);
    cmd.input_low_lockout <= 1'b1;
    st(2'h0, 20);
    tick(3);
    chk("switch_stop", 1, drive.switch_stop);
    bus(1'b0, 12'h008, 32'h0);
    chk("counts", 0, q);
    cmd.input_low_lockout <= 1'b0;
    cmd.overcurrent_guard <= 1'b0;
    recover();
    summarize();
  end
endmodule : regulator_fault_supervisor_tb_top
`default_nettype wire
